// ### src/amt_defs.svh
`ifndef AMT_DEFS_SVH
`define AMT_DEFS_SVH
// ==================================================
// Register byte addresses
`define AMT_ADDR_ABE       12'h000
`define AMT_ADDR_ROLE      12'h004
`define AMT_ADDR_CONV      12'h008
// ==================================================
// Field positions, analog block enable
`define AMT_ABE_DIG_OE     7
`define AMT_ABE_DSEL_HI    6
`define AMT_ABE_DSEL_LO    4
`define AMT_ABE_UVLO       3
`define AMT_ABE_ERROR_AMP_DISABLE      1
`define AMT_ABE_ANA_OE     0
`define AMT_ABE_MASK       8'hFB
// ==================================================
// Field positions, role and feedback
`define AMT_ROLE_HI        7
`define AMT_ROLE_LO        6
`define AMT_ROLE_RFB       5
`define AMT_ROLE_OPT       3
`define AMT_ROLE_MASK      8'hE8
// ==================================================
// Field positions, converter control
`define AMT_CONV_CHS_HI    6
`define AMT_CONV_CHS_LO    2
`define AMT_CONV_GO        1
`define AMT_CONV_ON        0
`define AMT_CONV_MASK      8'h7F
`define AMT_RESET_VAL      8'h00
// ==================================================
// Timing
`define AMT_CLK_MHZ        50
`define AMT_ONESHOT_NS     200
`define AMT_ONESHOT_CYC    ((`AMT_ONESHOT_NS * `AMT_CLK_MHZ + 999) / 1000)
`define AMT_CONV_CYC       24
`endif

// ### src/amt_pkg.sv
package amt_pkg;
  typedef enum logic [1:0] {
    AMT_ROLE_ALONE  = 2'b00,
    AMT_ROLE_MASTER = 2'b01,
    AMT_ROLE_SLAVE  = 2'b10,
    AMT_ROLE_SEMI   = 2'b11
  } amt_role_t;

  typedef enum logic [0:0] {
    AMT_CONV_IDLE = 1'b0,
    AMT_CONV_BUSY = 1'b1
  } amt_conv_state_t;

  // Digital sources feeding the test selector
  typedef struct packed {
    logic desat_comparator_out;
    logic pwm_mono;
    logic pwm_osc;
    logic timer_period_match;
    logic ov_comp;
    logic switching_freq_out;
    logic secondary_trigger;
  } amt_dig_src_t;

  // Pin routing produced by the role field
  typedef struct packed {
    logic ref_on_pin;
    logic ref_pin_gpo;
    logic sync_out_en;
    logic sync_in_en;
    logic sync_gpio;
  } amt_pinmap_t;
endpackage : amt_pkg

// ### src/amt_ctrl.sv
// Function
// - UVLO select resets 0 choosing 2.7V; set selects 5.4V.
// - EA disable resets 0; set parks amplifier output low.
// - Digital test enable drives selected digital signal onto test pin.
// - Three-bit select picks seven digital sources; code 111 gives nothing.
// - Secondary one-shot source is a 200 ns pulse resetting winding monitor.
// - Analog test enable connects analog mux output to test pin.
// - With both enables set, digital path wins the test pin.
// - Analog enable alone also routes analog signals to converter input.
// - Role 00 stand-alone: no reference, no sync on pins.
// - Role 01 master: reference to reference pin, sync clock out.
// - Role 10 slave: sync clock taken as input on sync pin.
// - Role 11 semi-master: option bit picks reference or sync mapping.
// - Feedback bit 0 uses internal resistor, 1 uses sense output pin.
// - Five-bit channel select: internal, reserved, unimplemented, external pins.
// - Chosen internal analog signal goes to test pin via buffer.
// - Go bit starts conversion, hardware clears it when done.
// - Converter-on bit enables converter; zero shuts it off.
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "amt_defs.svh"
module amt_ctrl (
  input  wire logic                  hclk,              // System clock, 50 MHz
  input  wire logic                  hresetn,           // Async reset, active low
  input  wire logic                  hsel,              // Slave select
  input  wire logic [11:0]           haddr,             // Byte address
  input  wire logic [1:0]            htrans,            // Transfer type
  input  wire logic                  hwrite,            // Write strobe
  input  wire logic [2:0]            hsize,             // Transfer size
  input  wire logic [31:0]           hwdata,            // Write data
  input  wire logic                  hready,            // Bus ready in
  output logic      [31:0]           hrdata,            // Read data
  output logic                       hreadyout,         // Slave ready
  output logic                       hresp,             // Always OKAY
  input  wire amt_pkg::amt_dig_src_t dig_src,           // Digital test sources
  input  wire logic                  sync_pin_in,       // Sync pin level
  input  wire logic                  conv_done,         // Converter finished
  output logic                       driver_uvlo_level_sel, // 1 = 5.4V lockout
  output logic                       error_amp_disable, // Park amplifier low
  output logic                       test_pin_dig_en,   // Digital drives test pin
  output logic                       test_pin_dig_val,  // Digital value on test pin
  output logic                       test_pin_ana_en,   // Analog buffer to test pin
  output logic                       adc_test_route,    // Analog test to converter
  output logic                       second_reference_en, // Reference to ref pin
  output logic                       ref_pin_gpo,       // Ref pin is general output
  output logic                       sync_clock_out_en, // Drive sync clock out
  output logic                       sync_clock_in_en,  // Sync pin is clock input
  output logic                       sync_gpio,         // Sync pin is general I/O
  output logic                       sync_clock_in,     // Filtered sync clock
  output logic                       sense_feedback_sel, // 1 = sense output pin
  output logic      [4:0]            analog_channel_sel, // Analog channel
  output logic                       chan_valid,        // Channel is implemented
  output logic                       converter_on,      // Converter powered
  output logic                       conv_start,        // Start pulse
  output logic                       secondary_one_shot, // 200 ns pulse
  output logic                       winding_monitor_rst // Winding monitor reset
);
  localparam logic [7:0] ABE_MASK  = `AMT_ABE_MASK;
  localparam logic [7:0] ROLE_MASK = `AMT_ROLE_MASK;
  localparam logic [7:0] CONV_MASK = `AMT_CONV_MASK;
  localparam logic [3:0] OS_CYC    = 4'(`AMT_ONESHOT_CYC);
  localparam logic [5:0] CONV_CYC  = 6'(`AMT_CONV_CYC);

  // ==================================================
  // Bus slave
  logic [7:0]  abe_reg;
  logic [7:0]  role_reg;
  logic [7:0]  conv_reg;
  logic        wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic        go_set;
  logic        go_clr;
  logic        rd_hit;
  logic [7:0]  rd_byte;

  assign rd_hit = hsel && hready && htrans[1] && !hwrite;

  always_comb begin
    case (haddr)
      `AMT_ADDR_ABE:  rd_byte = abe_reg;
      `AMT_ADDR_ROLE: rd_byte = role_reg;
      `AMT_ADDR_CONV: rd_byte = conv_reg;
      default:        rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else if (hready) begin
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      wr_addr_reg <= haddr;
    end
  end

  // Read data registered: single wait-free answer in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (rd_hit) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      abe_reg  <= `AMT_RESET_VAL;
      role_reg <= `AMT_RESET_VAL;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == `AMT_ADDR_ABE) begin
        abe_reg <= hwdata[7:0] & ABE_MASK;
      end
      if (wr_addr_reg == `AMT_ADDR_ROLE) begin
        role_reg <= hwdata[7:0] & ROLE_MASK;
      end
    end
  end

  // ==================================================
  // Converter control and go/done
  amt_pkg::amt_conv_state_t conv_state;
  logic [5:0]               conv_cnt;
  logic                     conv_wr;

  assign conv_wr = wr_pend_reg && (wr_addr_reg == `AMT_ADDR_CONV);
  // A go written with the converter off is dropped: nothing would ever finish it
  assign go_set  = conv_wr && hwdata[`AMT_CONV_GO] && hwdata[`AMT_CONV_ON];
  // Done comes from the converter or an internal fallback count
  assign go_clr  = (conv_state == amt_pkg::AMT_CONV_BUSY) &&
                   (conv_done || conv_cnt == CONV_CYC);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_reg <= `AMT_RESET_VAL;
    end else begin
      if (conv_wr) begin
        conv_reg[`AMT_CONV_CHS_HI:`AMT_CONV_CHS_LO] <=
          hwdata[`AMT_CONV_CHS_HI:`AMT_CONV_CHS_LO];
        conv_reg[`AMT_CONV_ON] <= hwdata[`AMT_CONV_ON];
      end
      // Start wins over completion in the same cycle
      if (go_set) begin
        conv_reg[`AMT_CONV_GO] <= 1'b1;
      end else if (go_clr || (conv_wr && !hwdata[`AMT_CONV_ON])) begin
        conv_reg[`AMT_CONV_GO] <= 1'b0;
      end
      conv_reg[7] <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_state <= amt_pkg::AMT_CONV_IDLE;
      conv_cnt   <= 6'h00;
      conv_start <= 1'b0;
    end else begin
      conv_start <= go_set;
      case (conv_state)
        amt_pkg::AMT_CONV_IDLE: begin
          conv_cnt <= 6'h00;
          if (go_set) begin
            conv_state <= amt_pkg::AMT_CONV_BUSY;
          end
        end
        amt_pkg::AMT_CONV_BUSY: begin
          conv_cnt <= conv_cnt + 6'h01;
          if (go_set) begin
            conv_cnt <= 6'h00;
          end else if (go_clr || !conv_reg[`AMT_CONV_ON]) begin
            conv_state <= amt_pkg::AMT_CONV_IDLE;
          end
        end
        default: conv_state <= amt_pkg::AMT_CONV_IDLE;
      endcase
    end
  end

  // ==================================================
  // Sync pin input synchroniser
  logic [2:0] sync_sr;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_sr       <= 3'h0;
      sync_clock_in <= 1'b0;
    end else begin
      sync_sr <= {sync_sr[1:0], sync_pin_in};
      if (sync_sr[1] == sync_sr[2] && sync_clock_in_en) begin
        sync_clock_in <= sync_sr[2];
      end
    end
  end

  // ==================================================
  // Secondary one-shot: rising trigger gives a fixed-width pulse
  logic       trig_d;
  logic [3:0] os_cnt;
  logic       os_next;

  // The detected edge is itself the first pulse cycle, so the pulse rises on the next clock
  assign os_next = (dig_src.secondary_trigger && !trig_d) || (os_cnt > 4'h1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_d             <= 1'b0;
      os_cnt             <= 4'h0;
      secondary_one_shot <= 1'b0;
      winding_monitor_rst <= 1'b0;
    end else begin
      trig_d <= dig_src.secondary_trigger;
      if (dig_src.secondary_trigger && !trig_d) begin
        os_cnt <= OS_CYC;
      end else if (os_cnt != 4'h0) begin
        os_cnt <= os_cnt - 4'h1;
      end
      secondary_one_shot  <= os_next;
      winding_monitor_rst <= os_next;
    end
  end

  // ==================================================
  // Test pin and analog routing
  logic dig_sel_val;
  logic dig_sel_ok;

  always_comb begin
    dig_sel_ok = 1'b1;
    case (abe_reg[`AMT_ABE_DSEL_HI:`AMT_ABE_DSEL_LO])
      3'h0:    dig_sel_val = dig_src.desat_comparator_out;
      3'h1:    dig_sel_val = dig_src.pwm_mono;
      3'h2:    dig_sel_val = dig_src.pwm_osc;
      3'h3:    dig_sel_val = dig_src.timer_period_match;
      3'h4:    dig_sel_val = dig_src.ov_comp;
      3'h5:    dig_sel_val = dig_src.switching_freq_out;
      3'h6:    dig_sel_val = secondary_one_shot;
      default: begin
        dig_sel_val = 1'b0;
        dig_sel_ok  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      driver_uvlo_level_sel <= 1'b0;
      error_amp_disable     <= 1'b0;
      test_pin_dig_en       <= 1'b0;
      test_pin_dig_val      <= 1'b0;
      test_pin_ana_en       <= 1'b0;
      adc_test_route        <= 1'b0;
    end else begin
      driver_uvlo_level_sel <= abe_reg[`AMT_ABE_UVLO];
      error_amp_disable     <= abe_reg[`AMT_ABE_ERROR_AMP_DISABLE];
      test_pin_dig_en       <= abe_reg[`AMT_ABE_DIG_OE];
      test_pin_dig_val      <= abe_reg[`AMT_ABE_DIG_OE] && dig_sel_ok && dig_sel_val;
      // Digital path has priority, so the buffer is cut off when both are set
      test_pin_ana_en       <= abe_reg[`AMT_ABE_ANA_OE] && !abe_reg[`AMT_ABE_DIG_OE];
      adc_test_route        <= abe_reg[`AMT_ABE_ANA_OE] && !abe_reg[`AMT_ABE_DIG_OE];
    end
  end

  // ==================================================
  // Channel classification and converter outputs
  logic chan_valid_next;

  // Reserved nodes and the unimplemented block are flagged so firmware can
  // tell a dead selection from a real zero reading
  always_comb begin
    case (conv_reg[`AMT_CONV_CHS_HI:`AMT_CONV_CHS_LO])
      5'h08, 5'h09: chan_valid_next = 1'b0;
      5'h10, 5'h11, 5'h12, 5'h13,
      5'h14, 5'h15, 5'h16, 5'h17: chan_valid_next = 1'b0;
      default: chan_valid_next = 1'b1;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_feedback_sel    <= 1'b0;
      analog_channel_sel    <= 5'h00;
      // Channel zero is an implemented node, so the flag starts valid
      chan_valid            <= 1'b1;
      converter_on          <= 1'b0;
    end else begin
      sense_feedback_sel    <= role_reg[`AMT_ROLE_RFB];
      analog_channel_sel    <= conv_reg[`AMT_CONV_CHS_HI:`AMT_CONV_CHS_LO];
      chan_valid            <= chan_valid_next;
      // Follows the write itself so a start pulse never leads the power-up
      if (conv_wr) begin
        converter_on        <= hwdata[`AMT_CONV_ON];
      end
    end
  end

  // ==================================================
  // Role pin mapping
  amt_pkg::amt_pinmap_t pm;

  always_comb begin
    pm = '0;
    case (amt_pkg::amt_role_t'(role_reg[`AMT_ROLE_HI:`AMT_ROLE_LO]))
      amt_pkg::AMT_ROLE_ALONE:  pm = '0;
      amt_pkg::AMT_ROLE_MASTER: begin
        pm.ref_on_pin  = 1'b1;
        pm.sync_out_en = 1'b1;
      end
      amt_pkg::AMT_ROLE_SLAVE:  pm.sync_in_en = 1'b1;
      amt_pkg::AMT_ROLE_SEMI: begin
        if (role_reg[`AMT_ROLE_OPT]) begin
          pm.ref_pin_gpo = 1'b1;
          pm.sync_out_en = 1'b1;
        end else begin
          pm.ref_on_pin = 1'b1;
          pm.sync_gpio  = 1'b1;
        end
      end
      default: pm = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_reference_en <= 1'b0;
      ref_pin_gpo         <= 1'b0;
      sync_clock_out_en   <= 1'b0;
      sync_clock_in_en    <= 1'b0;
      sync_gpio           <= 1'b0;
    end else begin
      second_reference_en <= pm.ref_on_pin;
      ref_pin_gpo         <= pm.ref_pin_gpo;
      sync_clock_out_en   <= pm.sync_out_en;
      sync_clock_in_en    <= pm.sync_in_en;
      sync_gpio           <= pm.sync_gpio;
    end
  end

  // Unused bus fields: size is always a word here
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, htrans[0], hwdata[31:8]};
endmodule : amt_ctrl
`default_nettype wire

// ### verif/amt_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module amt_ctrl_assertions (
  input wire logic                  hclk,                  // Clock
  input wire logic                  hresetn,               // Reset, active low
  input wire amt_pkg::amt_dig_src_t dig_src,               // Digital sources
  input wire logic                  test_pin_dig_en,       // Watched
  input wire logic                  test_pin_dig_val,      // Watched
  input wire logic                  test_pin_ana_en,       // Watched
  input wire logic                  adc_test_route,        // Watched
  input wire logic                  second_reference_en,   // Watched
  input wire logic                  ref_pin_gpo,           // Watched
  input wire logic                  sync_clock_out_en,     // Watched
  input wire logic                  sync_clock_in_en,      // Watched
  input wire logic [4:0]            analog_channel_sel,    // Watched
  input wire logic                  chan_valid,            // Watched
  input wire logic                  converter_on,          // Watched
  input wire logic                  conv_start,            // Watched
  input wire logic                  secondary_one_shot,    // Watched
  input wire logic                  winding_monitor_rst    // Watched
);
  // ==================================================
  // One-shot, test path, pin routing, converter start and channel checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_pulse10;
    secondary_one_shot[*8] ##1 secondary_one_shot[*2] ##1 !secondary_one_shot;
  endsequence
  sequence s_trig;
    $rose(dig_src.secondary_trigger) && !secondary_one_shot;
  endsequence
  a_oneshot_len: assert property ($rose(secondary_one_shot) |-> s_pulse10)
    else $error("one-shot width wrong");
  a_oneshot_trig: assert property (s_trig |-> ##[1:2] secondary_one_shot)
    else $error("one-shot did not start");
  a_wdm_follow: assert property (winding_monitor_rst == secondary_one_shot)
    else $error("winding reset differs from one-shot");
  a_digital_prio: assert property (test_pin_dig_en |-> !test_pin_ana_en)
    else $error("analog path on while digital enabled");
  a_adc_route: assert property (adc_test_route == test_pin_ana_en)
    else $error("converter route differs from analog path");
  a_dig_gated: assert property (!test_pin_dig_en |-> !test_pin_dig_val)
    else $error("digital value while path disconnected");
  a_sync_dir: assert property (sync_clock_in_en |-> !sync_clock_out_en)
    else $error("sync pin both input and output");
  a_ref_excl: assert property (second_reference_en |-> !ref_pin_gpo)
    else $error("reference pin double mapped");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_start_on: assert property (conv_start |-> converter_on)
    else $error("start while converter off");
  a_chan_impl: assert property (chan_valid == !(analog_channel_sel[4:3] == 2'b10 ||
    analog_channel_sel[4:1] == 4'b0100)) else $error("channel valid flag wrong");
endmodule : amt_ctrl_assertions
`default_nettype wire

// ### verif/amt_sync_peer.sv
`timescale 1ns/1ps
`default_nettype none
module amt_sync_peer (
  input  wire logic hclk,      // Bench clock
  input  wire logic hresetn,   // Reset, active low
  input  wire logic drive_en,  // Peer drives its sync clock
  output logic      sync_line  // Shared sync pin
);
  // ==================================================
  // Released line flips every cycle so a held level never passes as valid
  logic [1:0] cnt_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg   <= 2'h0;
      sync_line <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == 2'h2) ? 2'h0 : cnt_reg + 2'h1;
      if (!drive_en || cnt_reg == 2'h2) sync_line <= ~sync_line;
    end
  end
endmodule : amt_sync_peer
`default_nettype wire

// ### verif/tb_amt_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "amt_defs.svh"
module tb_amt_ctrl;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, conv_done = 1'b0;
  logic sync_en = 1'b0, hreadyout, hresp, sync_pin_in, test_pin_dig_en, test_pin_dig_val;
  logic driver_uvlo_level_sel, error_amp_disable, test_pin_ana_en, adc_test_route;
  logic second_reference_en, ref_pin_gpo, sync_clock_out_en, sync_clock_in_en, sync_gpio;
  logic sync_clock_in, sense_feedback_sel, chan_valid, converter_on, conv_start;
  logic secondary_one_shot, winding_monitor_rst;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [4:0] analog_channel_sel;
  amt_pkg::amt_dig_src_t dig_src = '0;
  int num_errors = 0, n_compared = 0, starts = 0;
  wire hready = hreadyout;
  amt_ctrl amt_ctrl_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .dig_src, .sync_pin_in, .conv_done,
    .driver_uvlo_level_sel, .error_amp_disable, .test_pin_dig_en, .test_pin_dig_val,
    .test_pin_ana_en, .adc_test_route, .second_reference_en, .ref_pin_gpo, .sync_clock_out_en,
    .sync_clock_in_en, .sync_gpio, .sync_clock_in, .sense_feedback_sel, .analog_channel_sel,
    .chan_valid, .converter_on, .conv_start, .secondary_one_shot, .winding_monitor_rst);
  amt_sync_peer amt_sync_peer_inst (.hclk, .hresetn, .drive_en(sync_en), .sync_line(sync_pin_in));
  always #10 hclk = ~hclk;
  always @(posedge hclk) if (conv_start === 1'b1) starts <= starts + 1;
  // ==================================================
  // Bus, compare and digital source tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
    @(posedge hclk);
    #1;
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    ahb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rdchk
  task automatic src(input logic [6:0] v);
    @(posedge hclk);
    dig_src <= amt_pkg::amt_dig_src_t'(v);
    repeat (2) @(posedge hclk);
    #1;
  endtask : src
  // ==================================================
  // Scenarios
  task automatic t_reset;
    rdchk(`AMT_ADDR_ABE, 32'h0, "abe_reset");
    rdchk(`AMT_ADDR_ROLE, 32'h0, "role_reset");
    rdchk(`AMT_ADDR_CONV, 32'h0, "conv_reset");
    chk("uvlo_reset", 0, driver_uvlo_level_sel);
    chk("error_amp_disable_reset", 0, error_amp_disable);
  endtask : t_reset
  task automatic t_abe;
    wr(`AMT_ADDR_ABE, 32'hFFFF_FFFF);
    rdchk(`AMT_ADDR_ABE, 32'hFB, "abe_rw");
    chk("uvlo_set", 1, driver_uvlo_level_sel);
    chk("error_amp_disable_set", 1, error_amp_disable);
    chk("dig_en_set", 1, test_pin_dig_en);
    chk("ana_blocked", 0, test_pin_ana_en);
    chk("adc_blocked", 0, adc_test_route);
    wr(`AMT_ADDR_ABE, 32'h01);
    chk("ana_en", 1, test_pin_ana_en);
    chk("adc_route", 1, adc_test_route);
    chk("dig_off", 0, test_pin_dig_en);
    chk("uvlo_clear", 0, driver_uvlo_level_sel);
    wr(12'h00C, 32'hFF);
    rdchk(12'h00C, 32'h0, "unmapped");
    chk("unmapped_resp", 0, hresp);
    rdchk(`AMT_ADDR_ABE, 32'h01, "abe_kept");
  endtask : t_abe
  task automatic t_dsel;
    for (int c = 0; c < 6; c++) begin
      wr(`AMT_ADDR_ABE, 32'h80 | (c << 4));
      src(7'h40 >> c);
      chk("dig_sel_hi", 1, test_pin_dig_val);
      src(7'h7E ^ (7'h40 >> c));
      chk("dig_sel_lo", 0, test_pin_dig_val);
    end
    wr(`AMT_ADDR_ABE, 32'hF0);
    chk("dig_code7", 0, test_pin_dig_val);
    src(7'h00);
  endtask : t_dsel
  task automatic t_oneshot;
    wr(`AMT_ADDR_ABE, 32'hE0);
    src(7'h01);
    chk("shot_on", 1, secondary_one_shot);
    chk("wdm_on", 1, winding_monitor_rst);
    chk("shot_pin", 1, test_pin_dig_val);
    repeat (12) @(posedge hclk);
    #1 chk("shot_off", 0, secondary_one_shot);
    chk("shot_pin_off", 0, test_pin_dig_val);
    src(7'h00);
  endtask : t_oneshot
  task automatic t_role;
    logic [7:0] rv [5] = '{8'h00, 8'h60, 8'h80, 8'hC0, 8'hE8};
    logic [4:0] em [5] = '{5'b00000, 5'b10100, 5'b00010, 5'b10001, 5'b01100};
    int n;
    logic last;
    for (int i = 0; i < 5; i++) begin
      @(posedge hclk) sync_en <= (i == 2);
      wr(`AMT_ADDR_ROLE, rv[i] | 8'h17);
      rdchk(`AMT_ADDR_ROLE, rv[i], "role_rw");
      chk("pin_map", em[i], {second_reference_en, ref_pin_gpo, sync_clock_out_en,
        sync_clock_in_en, sync_gpio});
      chk("feedback", rv[i][5], sense_feedback_sel);
      n = 0;
      last = sync_clock_in;
      repeat (24) begin
        @(posedge hclk);
        #1 if (sync_clock_in !== last) n++;
        last = sync_clock_in;
      end
      chk("sync_in_moves", i == 2, n > 0);
    end
  endtask : t_role
  task automatic t_chan;
    for (int c = 0; c < 32; c++) begin
      wr(`AMT_ADDR_CONV, c << 2);
      chk("chan_sel", c, analog_channel_sel);
      chk("chan_ok", !(c == 8 || c == 9 || (c >= 16 && c < 24)), chan_valid);
      rdchk(`AMT_ADDR_CONV, c << 2, "chan_rw");
    end
  endtask : t_chan
  task automatic t_conv;
    wr(`AMT_ADDR_CONV, 32'h02);
    rdchk(`AMT_ADDR_CONV, 32'h00, "go_off");
    chk("no_start", 0, starts);
    wr(`AMT_ADDR_CONV, 32'h01);
    chk("conv_on", 1, converter_on);
    wr(`AMT_ADDR_CONV, 32'h03);
    rdchk(`AMT_ADDR_CONV, 32'h03, "go_busy");
    chk("one_start", 1, starts);
    @(posedge hclk) conv_done <= 1'b1;
    @(posedge hclk) conv_done <= 1'b0;
    rdchk(`AMT_ADDR_CONV, 32'h01, "go_done");
    wr(`AMT_ADDR_CONV, 32'h03);
    repeat (30) @(posedge hclk);
    rdchk(`AMT_ADDR_CONV, 32'h01, "go_fallback");
    wr(`AMT_ADDR_CONV, 32'h00);
    chk("conv_off", 0, converter_on);
  endtask : t_conv
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_abe;
    t_dsel;
    t_oneshot;
    t_role;
    t_chan;
    t_conv;
    wr(`AMT_ADDR_ABE, 32'hFB);
    @(posedge hclk) hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    final_report;
  end
  initial begin
    #300000;
    num_errors++;
    final_report;
  end
endmodule : tb_amt_ctrl
bind amt_ctrl amt_ctrl_assertions chk_inst (.hclk, .hresetn, .dig_src, .test_pin_dig_en,
  .test_pin_dig_val, .test_pin_ana_en, .adc_test_route, .second_reference_en, .ref_pin_gpo,
  .sync_clock_out_en, .sync_clock_in_en, .analog_channel_sel, .chan_valid, .converter_on,
  .conv_start, .secondary_one_shot, .winding_monitor_rst);
`default_nettype wire
